// ==== common/ilox_defines.vh ====
// Constants for the indexed literal offset instruction executor.
`ifndef ILOX_DEFINES_VH
`define ILOX_DEFINES_VH
`define ILOX_OP_ADD_HI      4'h2
`define ILOX_OP_ADD_MID     2'h1
`define ILOX_OP_BSET_HI     4'h8
`define ILOX_OP_FILL_HI     4'h6
`define ILOX_OP_FILL_MID    4'h8
`define ILOX_OFFSET_MAX     8'h5f
`define ILOX_FILL_VALUE     8'hff
`define ILOX_ACC_RESET      8'h00
`define ILOX_FLAGS_RESET    5'h00
`define ILOX_ADDR_W         12
`define ILOX_FLAG_C         0
`define ILOX_FLAG_HC        1
`define ILOX_FLAG_Z         2
`define ILOX_FLAG_WRAP      3
`define ILOX_FLAG_N         4
`endif

// ==== verilog/ilox_addr_gen.v ====
// Effective data address former for indexed and literal operands.
`timescale 1ns/1ps
`include "ilox_defines.vh"
module ilox_addr_gen
(
	// Operand fields
	input  wire [7:0]               file_arg_in,
	input  wire                     access_sel_in,
	input  wire                     extended_set_enable_in,
	// Base registers
	input  wire [`ILOX_ADDR_W-1:0]  frame_pointer_in,
	input  wire [3:0]               bank_select_register_in,
	// Result
	output wire [`ILOX_ADDR_W-1:0]  addr_out,
	output wire                     indexed_out
);
	// Indexed only when enabled, access bank chosen and operand small.
	assign indexed_out = extended_set_enable_in & ~access_sel_in &
		(file_arg_in <= `ILOX_OFFSET_MAX);
	// Access bank low half sits at 000h, the high half at F60h onward.
	wire [`ILOX_ADDR_W-1:0] access_addr;
	assign access_addr = (file_arg_in <= `ILOX_OFFSET_MAX) ?
		{4'h0, file_arg_in} : {4'hf, file_arg_in};
	assign addr_out = indexed_out ?
		frame_pointer_in + {4'h0, file_arg_in} :
		(access_sel_in ? {bank_select_register_in, file_arg_in} :
		access_addr);
endmodule // ilox_addr_gen

// ==== verilog/ilox_exec.v ====
// Executor for add, bit set and fill in indexed literal offset mode.
// Summary of operation
// - Add acc to indexed byte, k 0..95; flags N, wrap, C, half carry, Z.
// - Destination bit 0 writes accumulator; 1 writes the memory byte.
// - Bit set indexed forces bit b of indexed byte; flags unchanged.
// - Fill indexed writes FFh to indexed byte; flags unchanged.
// - Enable bit low disables indexed addressing only; add, bit set and fill still execute.
// - Enabled, access bit 0, argument up to 5Fh means frame offset.
// - Disabled, embedded address is access bank or selected bank.
`timescale 1ns/1ps
`include "ilox_defines.vh"
module ilox_exec
(
	// Clock and reset
	input  wire                     clk_sys_in,
	input  wire                     arst_n_in,
	// Configuration and core state
	input  wire                     extended_set_enable_in,
	input  wire [`ILOX_ADDR_W-1:0]  frame_pointer_in,
	input  wire [3:0]               bank_select_register_in,
	// Instruction
	input  wire                     instr_valid_in,
	input  wire [15:0]              instr_in,
	// Data memory
	input  wire [7:0]               mem_rdata_in,
	output wire [`ILOX_ADDR_W-1:0]  mem_addr_out,
	output reg                      mem_we_out,
	output reg  [7:0]               mem_wdata_out,
	// Results
	output reg  [7:0]               acc_out,
	output reg  [4:0]               flags_out,
	output reg                      done_out,
	output reg                      illegal_out
);
	reg        rst_s1_q;
	reg        rst_n_q;
	always @(posedge clk_sys_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			rst_s1_q <= 1'b0;
			rst_n_q  <= 1'b0;
		end
		else
		begin
			rst_s1_q <= 1'b1;
			rst_n_q  <= rst_s1_q;
		end
	end

	// Operation classes decoded from the opcode.
	localparam [2:0] OPC_NONE = 3'h0;
	localparam [2:0] OPC_ADD  = 3'h1;
	localparam [2:0] OPC_BSET = 3'h2;
	localparam [2:0] OPC_FILL = 3'h3;
	localparam [2:0] OPC_ILL  = 3'h4;

	wire [3:0] opc_hi;
	wire [3:0] opc_mid;
	wire [7:0] file_arg;
	wire       is_add;
	wire       is_bset;
	wire       is_fill;
	wire       dest_mem;
	wire [2:0] bit_sel;
	wire       access_sel;
	assign opc_hi   = instr_in[15:12];
	assign opc_mid  = instr_in[11:8];
	assign file_arg = instr_in[7:0];
	assign is_add  = (opc_hi == `ILOX_OP_ADD_HI) &&
		(opc_mid[3:2] == `ILOX_OP_ADD_MID);
	assign is_bset = (opc_hi == `ILOX_OP_BSET_HI);
	assign is_fill = (opc_hi == `ILOX_OP_FILL_HI) &&
		(opc_mid == `ILOX_OP_FILL_MID);
	assign dest_mem = opc_mid[1];
	assign bit_sel  = opc_mid[3:1];
	// The fill opcode has no access bit of its own, so it counts as 0.
	assign access_sel = opc_mid[0] & ~is_fill;

	reg  [2:0] op_class;
	always @*
	begin
		op_class = OPC_NONE;
		if (instr_valid_in)
		begin
			if (is_add)
				op_class = OPC_ADD;
			else if (is_bset)
				op_class = OPC_BSET;
			else if (is_fill)
				op_class = OPC_FILL;
			else
				op_class = OPC_ILL;
		end
	end

	ilox_addr_gen u_addr
	(
		.file_arg_in             (file_arg),
		.access_sel_in           (access_sel),
		.extended_set_enable_in  (extended_set_enable_in),
		.frame_pointer_in        (frame_pointer_in),
		.bank_select_register_in (bank_select_register_in),
		.addr_out                (mem_addr_out),
		.indexed_out             ()
	);

	// Bit set data, one lane per data bit.
	wire [7:0] bit_onehot;
	wire [7:0] bset_data;
	assign bit_onehot = 8'h01 << bit_sel;
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : g_bset
			assign bset_data[gi] = mem_rdata_in[gi] | bit_onehot[gi];
		end
	endgenerate

	// Sum and flags are combinational so the read and the arithmetic
	// share the cycle in which the instruction is presented.
	wire [8:0] sum;
	wire [7:0] sum_byte;
	wire [4:0] low_sum;
	wire       carry;
	wire       half_carry;
	wire       zero;
	wire       negative;
	wire       wrap;
	assign sum        = {1'b0, acc_out} + {1'b0, mem_rdata_in};
	assign sum_byte   = sum[7:0];
	assign low_sum    = {1'b0, acc_out[3:0]} + {1'b0, mem_rdata_in[3:0]};
	assign carry      = sum[8];
	assign half_carry = low_sum[4];
	assign zero       = (sum_byte == 8'h00);
	assign negative   = sum_byte[7];
	// Signed wrap: both operands share a sign that the result lacks.
	assign wrap       = (acc_out[7] == mem_rdata_in[7]) &&
		(sum_byte[7] != acc_out[7]);

	reg  [7:0] acc_d;
	reg  [4:0] flags_d;
	reg        we_d;
	reg  [7:0] wdata_d;
	reg        done_d;
	reg        illegal_d;

	always @*
	begin
		acc_d     = acc_out;
		flags_d   = flags_out;
		we_d      = 1'b0;
		wdata_d   = mem_wdata_out;
		done_d    = 1'b0;
		illegal_d = 1'b0;
		case (op_class)
			OPC_ADD:
			begin
				done_d = 1'b1;
				if (dest_mem)
				begin
					we_d    = 1'b1;
					wdata_d = sum_byte;
				end
				else
					acc_d = sum_byte;
				flags_d[`ILOX_FLAG_C]    = carry;
				flags_d[`ILOX_FLAG_HC]   = half_carry;
				flags_d[`ILOX_FLAG_Z]    = zero;
				flags_d[`ILOX_FLAG_WRAP] = wrap;
				flags_d[`ILOX_FLAG_N]    = negative;
			end

			OPC_BSET:
			begin
				done_d  = 1'b1;
				we_d    = 1'b1;
				wdata_d = bset_data;
			end

			OPC_FILL:
			begin
				done_d  = 1'b1;
				we_d    = 1'b1;
				wdata_d = `ILOX_FILL_VALUE;
			end

			OPC_ILL:
				illegal_d = 1'b1;

			default:
			begin
				// No instruction this cycle; acc, flags and write data hold, done and illegal clear.
				done_d    = 1'b0;
				illegal_d = 1'b0;
			end
		endcase
	end

	// Results are registered: the write pulse trails the instruction by one
	// cycle, so the memory has to keep the address that came with it.
	always @(posedge clk_sys_in or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			acc_out       <= `ILOX_ACC_RESET;
			flags_out     <= `ILOX_FLAGS_RESET;
			mem_we_out    <= 1'b0;
			mem_wdata_out <= 8'h00;
			done_out      <= 1'b0;
			illegal_out   <= 1'b0;
		end
		else
		begin
			acc_out       <= acc_d;
			flags_out     <= flags_d;
			mem_we_out    <= we_d;
			mem_wdata_out <= wdata_d;
			done_out      <= done_d;
			illegal_out   <= illegal_d;
		end
	end
endmodule // ilox_exec

// ==== dv/ilox_exec_assertions.sv ====
// Checker for the indexed offset executor.
`timescale 1ns/1ps
module ilox_exec_chk
(
	input wire logic        clk_sys_in, arst_n_in, instr_valid_in,
	input wire logic        extended_set_enable_in, mem_we_out,
	input wire logic        done_out, illegal_out,
	input wire logic [11:0] frame_pointer_in, mem_addr_out,
	input wire logic [3:0]  bank_select_register_in,
	input wire logic [15:0] instr_in,
	input wire logic [7:0]  mem_rdata_in, mem_wdata_out, acc_out,
	input wire logic [4:0]  flags_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	wire       v = instr_valid_in;
	wire [7:0] k = instr_in[7:0];
	wire       ad = instr_in[15:10] == 6'h09;
	wire       bs = instr_in[15:12] == 4'h8;
	wire       fl = instr_in[15:8] == 8'h68;
	wire       op = ad || bs || fl;
	wire       ix = extended_set_enable_in && !instr_in[8] && k <= 8'h5f;
	reg  [8:0] s_q;
	reg  [7:0] b_q;
	reg  [4:0] h_q;
	reg  [1:0] w_q;
	// Expected results are kept a cycle so they meet the registered answer.
	always @(posedge clk_sys_in)
	begin
		s_q <= acc_out + mem_rdata_in;
		b_q <= mem_rdata_in | 8'h01 << instr_in[11:9];
		h_q <= acc_out[3:0] + mem_rdata_in[3:0];
		w_q <= {acc_out[7], mem_rdata_in[7]};
	end
	AST_ADDR: assert property (v && op && ix |->
		mem_addr_out == frame_pointer_in + k) else $error("indexed address");
	AST_LIT: assert property (v && op && !extended_set_enable_in |->
		mem_addr_out == (instr_in[8] ? {bank_select_register_in, k} :
		{{4{k > 8'h5f}}, k})) else $error("literal address");
	AST_FILL: assert property (v && fl |=> mem_we_out &&
		mem_wdata_out == 8'hff && $stable(flags_out)) else $error("fill");
	AST_BSET: assert property (v && bs |=> mem_we_out &&
		mem_wdata_out == b_q && $stable(flags_out)) else $error("bit set");
	AST_ADDW: assert property (v && ad && !instr_in[9] |=> done_out &&
		!mem_we_out && acc_out == s_q[7:0]) else $error("add to acc");
	AST_ADDF: assert property (v && ad && instr_in[9] |=> mem_we_out &&
		mem_wdata_out == s_q[7:0] && $stable(acc_out)) else $error("add to mem");
	AST_FLAG: assert property (v && ad |=> flags_out[0] == s_q[8] &&
		flags_out[2] == (s_q[7:0] == 8'h00) && flags_out[4] == s_q[7])
		else $error("add flags");
	AST_HCWR: assert property (v && ad |=> flags_out[1] == h_q[4] &&
		flags_out[3] == (w_q[1] == w_q[0] && s_q[7] != w_q[1]))
		else $error("add half carry or wrap");
	AST_ILL: assert property (v && !op |=> illegal_out && !done_out &&
		!mem_we_out) else $error("illegal opcode");
	AST_WE: assert property (mem_we_out |-> $past(instr_valid_in))
		else $error("stray write");
	cover property (v && ad && instr_in[9]);
	cover property (v && bs);
	cover property (v && fl && !extended_set_enable_in);
endmodule // ilox_exec_chk
bind ilox_exec ilox_exec_chk u_chk (.*);

// ==== dv/tb_top.sv ====
// Self-checking bench for the indexed offset executor.
`timescale 1ns/1ps
module tb_top;
	logic        clk_sys_in = 0, arst_n_in = 0, en = 1, v = 0;
	logic [11:0] fp = 12'ha00, wa, ma;
	logic [15:0] ins = 16'h0000;
	logic [7:0]  mem [0:4095], wd, acc;
	logic [4:0]  fl;
	logic        we, dn, ill, ill_s, dn_s;
	logic [3:0]  bank_select_register = 4'h3;
	int          errors = 0, cmp_count = 0;
	ilox_exec u_dut (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
		.extended_set_enable_in(en), .frame_pointer_in(fp),
		.bank_select_register_in(bank_select_register), .instr_valid_in(v), .instr_in(ins),
		.mem_rdata_in(mem[ma]), .mem_addr_out(ma), .mem_we_out(we),
		.mem_wdata_out(wd), .acc_out(acc), .flags_out(fl), .done_out(dn),
		.illegal_out(ill));
	initial forever #2 clk_sys_in = ~clk_sys_in;
	// The write lands a cycle late, so the issuing address is latched.
	always @(posedge clk_sys_in)
	begin
		if (v) wa <= ma;
		if (we) mem[wa] <= wd;
	end
	task chk(input string n, input logic [11:0] e, g);
		cmp_count++;
		if (e !== g)
		begin
			errors++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	task ex(input logic [15:0] x);
		@(posedge clk_sys_in);
		v <= 1;
		ins <= x;
		@(posedge clk_sys_in);
		v <= 0;
		@(negedge clk_sys_in);
		ill_s = ill;
		dn_s = dn;
		@(negedge clk_sys_in);
	endtask
	task t_add;
		mem[12'ha05] = 8'h17;
		mem[12'ha2c] = 8'h20;
		mem[12'ha5f] = 8'hc9;
		ex(16'h2405);
		ex(16'h242c);
		chk("acc", 12'h037, {4'h0, acc});
		ex(16'h265f);
		chk("sum", 12'h000, {4'h0, mem[12'ha5f]});
		chk("flags", 12'h007, {7'h00, fl});
		mem[12'ha10] = 8'h50;
		ex(16'h2410);
		chk("acc", 12'h087, {4'h0, acc});
		chk("flags", 12'h018, {7'h00, fl});
	endtask
	task t_bset;
		logic [7:0] e;
		e = 8'h55;
		fp <= 12'hfff;
		mem[12'h00a] = 8'h55;
		for (int b = 0; b < 8; b++)
		begin
			e[b] = 1'b1;
			ex({4'h8, b[2:0], 9'h00b});
			chk("bit", {4'h0, e}, {4'h0, mem[12'h00a]});
		end
		chk("flags", 12'h018, {7'h00, fl});
	endtask
	task t_mode;
		fp <= 12'ha00;
		ex(16'h682c);
		chk("fill", 12'h0ff, {4'h0, mem[12'ha2c]});
		chk("done", 12'h001, {11'h000, dn_s});
		en <= 0;
		ex(16'h6860);
		chk("lit", 12'h0ff, {4'h0, mem[12'hf60]});
		ex(16'h8120);
		chk("bank", 12'h001, {4'h0, mem[12'h320]});
		ex(16'h8005);
		chk("low", 12'h001, {4'h0, mem[12'h005]});
		bank_select_register <= 4'h7;
		ex(16'h8120);
		chk("bank", 12'h001, {4'h0, mem[12'h720]});
		ex(16'hffff);
		chk("ill", 12'h001, {11'h000, ill_s});
		chk("done", 12'h000, {11'h000, dn_s});
		en <= 1;
		ex(16'h8261);
		chk("high", 12'h002, {4'h0, mem[12'hf61]});
	endtask
	task t_reset;
		arst_n_in <= 0;
		repeat (2) @(posedge clk_sys_in);
		chk("rst acc", 12'h000, {4'h0, acc});
		chk("rst flags", 12'h000, {7'h00, fl});
		arst_n_in <= 1;
		repeat (3) @(posedge clk_sys_in);
		ex(16'h2405);
		chk("acc", 12'h017, {4'h0, acc});
	endtask
	task results;
		if (errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
		repeat (6) @(posedge clk_sys_in);
		arst_n_in <= 1;
		repeat (3) @(posedge clk_sys_in);
		t_add;
		t_bset;
		t_mode;
		t_reset;
		results;
	end
	initial
	begin
		#20000;
		errors++;
		results;
	end
endmodule // tb_top
